// ===== inc/dvsr_pkg.sv
// Purpose: Shared constants and types of the digital volume soft-ramp stage
// Assumes: One mclk domain; gain codes count up toward quieter, 0xFF is mute
// Notes: Register offsets are byte addresses on the control register port
package dvsr_pkg;

    // Register offsets
    localparam logic [7:0] DVSR_ADDR_LINK = 8'h3C;
    localparam logic [7:0] DVSR_ADDR_LEFT = 8'h3D;
    localparam logic [7:0] DVSR_ADDR_RIGHT = 8'h3E;
    localparam logic [7:0] DVSR_ADDR_RAMP = 8'h3F;

    // Reset values
    localparam logic [7:0] DVSR_RST_LINK = 8'h00;
    localparam logic [7:0] DVSR_RST_GAIN = 8'h30;
    localparam logic [7:0] DVSR_RST_RAMP = 8'h33;
    localparam logic [7:0] DVSR_READ_UNMAPPED = 8'h00;

    // Field positions
    localparam int DVSR_LINK_LSB = 0;
    localparam int DVSR_DOWN_RATE_LSB = 6;
    localparam int DVSR_DOWN_STEP_LSB = 4;
    localparam int DVSR_UP_RATE_LSB = 2;
    localparam int DVSR_UP_STEP_LSB = 0;

    // Gain codes
    localparam logic [7:0] DVSR_GAIN_MUTE = 8'hFF;

    // Link field codes
    localparam logic [1:0] DVSR_LINK_INDEPENDENT = 2'h0;
    localparam logic [1:0] DVSR_LINK_FOLLOW_LEFT = 2'h1;

    // Rate code that bypasses the ramp
    localparam logic [1:0] DVSR_RATE_INSTANT = 2'h3;

    // Step sizes in half-dB code units: 4, 2, 1 and 0.5 dB
    localparam logic [7:0] DVSR_STEP_4DB = 8'h08;
    localparam logic [7:0] DVSR_STEP_2DB = 8'h04;
    localparam logic [7:0] DVSR_STEP_1DB = 8'h02;
    localparam logic [7:0] DVSR_STEP_HALF_DB = 8'h01;

    // Ramp states, Gray coded along idle, down, muted, up
    typedef enum logic [1:0] {
        DVSR_ST_IDLE = 2'b00,
        DVSR_ST_DOWN = 2'b01,
        DVSR_ST_MUTED = 2'b11,
        DVSR_ST_UP = 2'b10
    } dvsr_state_t;

endpackage

// ===== hw/dvsr_ramp.sv
// Purpose: One channel of soft mute / unmute gain ramping
// Assumes: fs_tick is a one-cycle pulse once per sample period
// Notes: gain_reg is the code applied to the data path
`timescale 1ns/1ps
module dvsr_ramp
    import dvsr_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic fs_tick,
    input wire logic mute_req,
    input wire logic [7:0] target,
    input wire logic [1:0] ramp_down_rate,
    input wire logic [1:0] ramp_down_step,
    input wire logic [1:0] ramp_up_rate,
    input wire logic [1:0] ramp_up_step,
    output logic [7:0] gain_reg,
    output logic ramping_reg
);

    dvsr_state_t state_reg;
    dvsr_state_t state_next;
    logic [7:0] gain_next;
    logic [1:0] tick_cnt_reg;
    logic [1:0] tick_cnt_next;
    logic ramping_next;
    logic [1:0] rate;
    logic [1:0] ticks_max;
    logic update;
    logic [7:0] step;
    logic [8:0] down_sum;
    logic [7:0] up_gap;

    function automatic logic [7:0] step_size(input logic [1:0] code);
        case (code)
            2'h0: step_size = DVSR_STEP_4DB;
            2'h1: step_size = DVSR_STEP_2DB;
            2'h2: step_size = DVSR_STEP_1DB;
            default: step_size = DVSR_STEP_HALF_DB;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        rate = (state_reg == DVSR_ST_UP) ? ramp_up_rate : ramp_down_rate;
        ticks_max = (rate == 2'h0) ? 2'h0 : ((rate == 2'h1) ? 2'h1 : 2'h3);
        update = fs_tick && (tick_cnt_reg == ticks_max);
        step = (state_reg == DVSR_ST_UP) ? step_size(ramp_up_step) : step_size(ramp_down_step);
        down_sum = {1'b0, gain_reg} + {1'b0, step};
        up_gap = gain_reg - target;
        state_next = state_reg;
        gain_next = gain_reg;
        tick_cnt_next = tick_cnt_reg;
        if (fs_tick) begin
            tick_cnt_next = update ? 2'h0 : tick_cnt_reg + 2'h1;
        end
        case (state_reg)
            DVSR_ST_IDLE: begin
                gain_next = target;
                tick_cnt_next = 2'h0;
                if (mute_req) begin
                    if (ramp_down_rate == DVSR_RATE_INSTANT) begin
                        gain_next = DVSR_GAIN_MUTE;
                        state_next = DVSR_ST_MUTED;
                    end else begin
                        gain_next = gain_reg;
                        state_next = DVSR_ST_DOWN;
                    end
                end
            end
            DVSR_ST_DOWN: begin
                if (!mute_req) begin
                    state_next = DVSR_ST_UP;
                    tick_cnt_next = 2'h0;
                end else if (ramp_down_rate == DVSR_RATE_INSTANT) begin
                    gain_next = DVSR_GAIN_MUTE;
                    state_next = DVSR_ST_MUTED;
                end else if (update) begin
                    if (down_sum >= {1'b0, DVSR_GAIN_MUTE}) begin
                        gain_next = DVSR_GAIN_MUTE;
                        state_next = DVSR_ST_MUTED;
                    end else begin
                        gain_next = down_sum[7:0];
                    end
                end
            end
            DVSR_ST_MUTED: begin
                gain_next = DVSR_GAIN_MUTE;
                tick_cnt_next = 2'h0;
                if (!mute_req) begin
                    state_next = DVSR_ST_UP;
                end
            end
            DVSR_ST_UP: begin
                if (mute_req) begin
                    state_next = DVSR_ST_DOWN;
                    tick_cnt_next = 2'h0;
                end else if (ramp_up_rate == DVSR_RATE_INSTANT || gain_reg <= target) begin
                    gain_next = target;
                    state_next = DVSR_ST_IDLE;
                end else if (update) begin
                    if (up_gap <= step) begin
                        gain_next = target;
                        state_next = DVSR_ST_IDLE;
                    end else begin
                        gain_next = gain_reg - step;
                    end
                end
            end
            default: begin
                state_next = DVSR_ST_IDLE;
            end
        endcase
        ramping_next = (state_next == DVSR_ST_DOWN) || (state_next == DVSR_ST_UP);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_reg <= DVSR_ST_IDLE;
            gain_reg <= DVSR_RST_GAIN;
            tick_cnt_reg <= 2'h0;
            ramping_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            gain_reg <= gain_next;
            tick_cnt_reg <= tick_cnt_next;
            ramping_reg <= ramping_next;
        end
    end

endmodule // dvsr_ramp

// ===== hw/dvsr_top.sv
// Purpose: Stereo digital volume registers with soft mute ramping
// Assumes: Register port and pins synchronous to mclk
// Notes: One tagged line per rule below
// Functional notes
// - Link field: 00 independent channels, 01 right follows left setting.
// - Left gain code: 0x00 is +24 dB, 0.5 dB steps, 0xFF mute, reset 0x30.
// - Right gain code identical to left, reset to 0 dB code.
// - Ramp-down update every 1, 2, 4 sample periods; code 11 mutes instantly.
// - Ramp-down step 4, 2, 1 or 0.5 dB; reset code 11.
// - Pin or register soft mute both use the normal ramp settings.
// - Ramp-up update every 1, 2, 4 sample periods; code 11 restores instantly.
// - Ramp-up step 4, 2, 1 or 0.5 dB; reset code 11.
`timescale 1ns/1ps
module dvsr_top
    import dvsr_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic fs_tick,
    input wire logic soft_mute_pin_n,
    input wire logic soft_mute_register,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic [7:0] left_gain_now,
    output logic [7:0] right_gain_now,
    output logic left_ramping,
    output logic right_ramping
);

    logic [7:0] link_reg;
    logic [7:0] link_next;
    logic [7:0] left_reg;
    logic [7:0] left_next;
    logic [7:0] right_reg;
    logic [7:0] right_next;
    logic [7:0] ramp_reg;
    logic [7:0] ramp_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [1:0] volume_link_field;
    logic [7:0] right_target;
    logic mute_req;
    logic [1:0] ramp_down_rate;
    logic [1:0] ramp_down_step;
    logic [1:0] ramp_up_rate;
    logic [1:0] ramp_up_step;

    ////////////////////////////////////////////////////////////////////////
    // Register writes and reads
    always_comb begin
        link_next = link_reg;
        left_next = left_reg;
        right_next = right_reg;
        ramp_next = ramp_reg;
        if (reg_wr_en) begin
            if (reg_addr == DVSR_ADDR_LINK) begin
                link_next = reg_wdata;
            end else if (reg_addr == DVSR_ADDR_LEFT) begin
                left_next = reg_wdata;
            end else if (reg_addr == DVSR_ADDR_RIGHT) begin
                right_next = reg_wdata;
            end else if (reg_addr == DVSR_ADDR_RAMP) begin
                ramp_next = reg_wdata;
            end
        end
        rdata_next = rdata_reg;
        if (reg_rd_en) begin
            if (reg_addr == DVSR_ADDR_LINK) begin
                rdata_next = link_reg;
            end else if (reg_addr == DVSR_ADDR_LEFT) begin
                rdata_next = left_reg;
            end else if (reg_addr == DVSR_ADDR_RIGHT) begin
                rdata_next = right_reg;
            end else if (reg_addr == DVSR_ADDR_RAMP) begin
                rdata_next = ramp_reg;
            end else begin
                rdata_next = DVSR_READ_UNMAPPED;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            link_reg <= DVSR_RST_LINK;
            left_reg <= DVSR_RST_GAIN;
            right_reg <= DVSR_RST_GAIN;
            ramp_reg <= DVSR_RST_RAMP;
            rdata_reg <= DVSR_READ_UNMAPPED;
        end else begin
            link_reg <= link_next;
            left_reg <= left_next;
            right_reg <= right_next;
            ramp_reg <= ramp_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Field decode, link and mute request
    always_comb begin
        volume_link_field = link_reg[DVSR_LINK_LSB +: 2];
        right_target = (volume_link_field == DVSR_LINK_FOLLOW_LEFT) ? left_reg : right_reg;
        mute_req = !soft_mute_pin_n || soft_mute_register;
        ramp_down_rate = ramp_reg[DVSR_DOWN_RATE_LSB +: 2];
        ramp_down_step = ramp_reg[DVSR_DOWN_STEP_LSB +: 2];
        ramp_up_rate = ramp_reg[DVSR_UP_RATE_LSB +: 2];
        ramp_up_step = ramp_reg[DVSR_UP_STEP_LSB +: 2];
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel ramps
    dvsr_ramp u_left (
        .mclk(mclk),
        .resetn(resetn),
        .fs_tick(fs_tick),
        .mute_req(mute_req),
        .target(left_reg),
        .ramp_down_rate(ramp_down_rate),
        .ramp_down_step(ramp_down_step),
        .ramp_up_rate(ramp_up_rate),
        .ramp_up_step(ramp_up_step),
        .gain_reg(left_gain_now),
        .ramping_reg(left_ramping)
    );

    dvsr_ramp u_right (
        .mclk(mclk),
        .resetn(resetn),
        .fs_tick(fs_tick),
        .mute_req(mute_req),
        .target(right_target),
        .ramp_down_rate(ramp_down_rate),
        .ramp_down_step(ramp_down_step),
        .ramp_up_rate(ramp_up_rate),
        .ramp_up_step(ramp_up_step),
        .gain_reg(right_gain_now),
        .ramping_reg(right_ramping)
    );

endmodule // dvsr_top

// ===== sim/dvsr_props.sv
// Purpose: Port assertions for the volume soft-ramp stage
// Assumes: One mclk domain, synchronous active-low reset
// Notes: Gain step and tick pacing checks skip cycles near register writes
`timescale 1ns/1ps
module dvsr_props
    import dvsr_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic fs_tick,
    input wire logic soft_mute_pin_n,
    input wire logic soft_mute_register,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] left_gain_now,
    input wire logic [7:0] right_gain_now,
    input wire logic left_ramping,
    input wire logic right_ramping
);
    logic mute_d1_reg, mute_d2_reg, rst_d1_reg, wr_d1_reg, wr_d2_reg;
    logic [7:0] ramp_cfg_reg;
    // Shadow of the ramp settings, rebuilt from the register port
    wire logic [8:0] down_step = 9'h008 >> ramp_cfg_reg[DVSR_DOWN_STEP_LSB +: 2];
    wire logic [8:0] up_step = 9'h008 >> ramp_cfg_reg[DVSR_UP_STEP_LSB +: 2];
    wire logic down_instant = ramp_cfg_reg[DVSR_DOWN_RATE_LSB +: 2] == DVSR_RATE_INSTANT;
    wire logic up_instant = ramp_cfg_reg[DVSR_UP_RATE_LSB +: 2] == DVSR_RATE_INSTANT;
    wire logic mute_any = !soft_mute_pin_n || soft_mute_register;
    // Direction steady for two cycles, no recent write or reset
    wire logic calm = rst_d1_reg && !wr_d1_reg && !wr_d2_reg && mute_d1_reg == mute_d2_reg;
    always_ff @(posedge mclk) begin
        mute_d1_reg <= mute_any;
        mute_d2_reg <= mute_d1_reg;
        rst_d1_reg <= resetn;
        wr_d1_reg <= reg_wr_en;
        wr_d2_reg <= wr_d1_reg;
        if (!resetn) begin
            ramp_cfg_reg <= DVSR_RST_RAMP;
        end else if (reg_wr_en && reg_addr == DVSR_ADDR_RAMP) begin
            ramp_cfg_reg <= reg_wdata;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    a_left_down_step: assert property ($past(left_ramping) && calm && mute_d1_reg && !down_instant
        |-> left_gain_now >= $past(left_gain_now) && left_gain_now <= $past(left_gain_now) + down_step)
        else $error("left ramp down step wrong");
    a_right_down_step: assert property ($past(right_ramping) && calm && mute_d1_reg && !down_instant
        |-> right_gain_now >= $past(right_gain_now) && right_gain_now <= $past(right_gain_now) + down_step)
        else $error("right ramp down step wrong");
    a_left_up_step: assert property ($past(left_ramping) && calm && !mute_d1_reg && !up_instant
        |-> left_gain_now <= $past(left_gain_now) && left_gain_now + up_step >= $past(left_gain_now))
        else $error("left ramp up step wrong");
    a_tick_paces_gain: assert property ($past(left_ramping) && calm && !$past(fs_tick)
        && !(mute_d1_reg ? down_instant : up_instant)
        |-> $stable(left_gain_now)) else $error("gain moved without sample tick");
    a_mute_starts_ramp: assert property ($rose(mute_any) && !left_ramping && left_gain_now != 8'hFF
        |=> left_ramping || left_gain_now == DVSR_GAIN_MUTE) else $error("mute request not taken");
    a_down_ends_mute: assert property ($fell(left_ramping) && rst_d1_reg && mute_d1_reg
        |-> left_gain_now == DVSR_GAIN_MUTE) else $error("ramp down stopped short of mute");
    a_unmapped_zero: assert property (reg_rd_en && (reg_addr < 8'h3C || reg_addr > 8'h3F)
        |=> reg_rdata == DVSR_READ_UNMAPPED) else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd_en |=> $stable(reg_rdata)) else $error("read data changed");
endmodule // dvsr_props
bind dvsr_top dvsr_props dvsr_props_inst (.mclk, .resetn, .fs_tick, .soft_mute_pin_n, .soft_mute_register,
    .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .left_gain_now, .right_gain_now,
    .left_ramping, .right_ramping);

// ===== sim/test_digital_volume_soft_ramp.sv
// Purpose: Self-checking bench for the volume soft-ramp stage
// Assumes: fs_tick pulses every second mclk cycle
// Notes: Ramp model tracks expected gain per update
`timescale 1ns/1ps
module test_digital_volume_soft_ramp
    import dvsr_pkg::*;
;
    logic mclk, resetn, fs_tick, soft_mute_pin_n, soft_mute_register, reg_wr_en, reg_rd_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, left_gain_now, right_gain_now;
    logic left_ramping, right_ramping;
    int errors, total_checks, tl, tr;
    int model[4];
    dvsr_top dvsr_top_inst (.mclk, .resetn, .fs_tick, .soft_mute_pin_n, .soft_mute_register, .reg_wr_en,
        .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .left_gain_now, .right_gain_now, .left_ramping,
        .right_ramping);
    initial begin
        mclk = 0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) fs_tick <= ~fs_tick;
    ////////////////////////////////////////
    task chk(string what, int exp, logic [7:0] got);
        total_checks++;
        if (got !== exp[7:0]) begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task wr(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        reg_wr_en <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr_en <= 0;
        if (a >= 8'h3C && a <= 8'h3F)
            model[a[1:0]] = d;
    endtask
    task rd(logic [7:0] a);
        @(posedge mclk);
        reg_rd_en <= 1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd_en <= 0;
        #1 chk("read data", (a >= 8'h3C && a <= 8'h3F) ? model[a[1:0]] : 0, reg_rdata);
    endtask
    // Follows one ramp on the left channel, then waits for both to settle
    task watch(bit dn, int rate, int step, int tgt);
        int k, ticks, eg, s;
        logic [7:0] last;
        s = 8 >> step;
        eg = dn ? tl : 255;
        last = left_gain_now;
        ticks = 0;
        for (k = 0; k < 6000 && eg != tgt; k++) begin
            @(posedge mclk);
            #1;
            if (left_gain_now !== last) begin
                eg = rate == 3 ? tgt : dn ? (eg + s > tgt ? tgt : eg + s) : (eg - s < tgt ? tgt : eg - s);
                chk("gain step", eg, left_gain_now);
                chk("ramping flag", eg != tgt, left_ramping);
                if (rate != 3)
                    chk("ticks per step", 1 << rate, ticks[7:0]);
                ticks = 0;
                last = left_gain_now;
            end
            // Ticks the design sees in this cycle, applied at the next edge
            ticks += left_ramping && fs_tick;
        end
        for (; k < 9000 && (left_ramping || right_ramping); k++) begin
            @(posedge mclk);
            #1;
        end
        if (k >= 6000) begin
            errors++;
            conclude;
        end
    endtask
    ////////////////////////////////////////
    initial begin
        {fs_tick, reg_wr_en, reg_rd_en, soft_mute_register, resetn} = 0;
        soft_mute_pin_n = 1;
        reg_addr = 0;
        reg_wdata = 0;
        errors = 0;
        total_checks = 0;
        model = '{8'h00, 8'h30, 8'h30, 8'h33};
        void'($urandom(32'h0f96299b));
        repeat (10) @(posedge mclk);
        resetn <= 1;
        #1 chk("left gain at reset", 8'h30, left_gain_now);
        chk("right gain at reset", 8'h30, right_gain_now);
        for (int i = 0; i < 5; i++) rd(8'h3C + i);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h3C + i, 8'($urandom));
            rd(8'h3C + i);
        end
        wr(8'h41, 8'hA5);
        rd(8'h41);
        $display("register test done");
        wr(8'h3C, 8'h01);
        wr(8'h3D, 8'h55);
        wr(8'h3E, 8'h20);
        repeat (2) @(posedge mclk);
        #1 chk("right follows left", 8'h55, right_gain_now);
        wr(8'h3C, 8'h00);
        repeat (2) @(posedge mclk);
        #1 chk("right independent", 8'h20, right_gain_now);
        $display("link test done");
        for (int i = 0; i < 16; i++) begin
            tl = $urandom_range(254, 0);
            tr = $urandom_range(254, 0);
            wr(8'h3F, {i[3:0], ~i[3:0]});
            wr(8'h3D, tl[7:0]);
            wr(8'h3E, tr[7:0]);
            repeat (2) @(posedge mclk);
            #1 chk("left idle gain", tl, left_gain_now);
            chk("right idle gain", tr, right_gain_now);
            @(posedge mclk);
            soft_mute_pin_n <= i[0];
            soft_mute_register <= i[0];
            watch(1, i[3:2], i[1:0], 255);
            chk("right muted", 255, right_gain_now);
            @(posedge mclk);
            soft_mute_pin_n <= 1;
            soft_mute_register <= 0;
            watch(0, 3 - i[3:2], 3 - i[1:0], tl);
            chk("right restored", tr, right_gain_now);
        end
        $display("ramp test done");
        conclude;
    end
endmodule // test_digital_volume_soft_ramp
